// File: design/cop_port_pkg.sv
// shared constants and carrier types for the coprocessor data bus port
package cop_port_pkg;
  localparam int DATA_W = 32;
  localparam int FN_W = 4;
  localparam int DP_W = 3;
  localparam int ADDR_W = 4;
  localparam int CMD_W = 8;
  localparam int PORT_BIT = 18;
  localparam int CMD_HI = 17;
  localparam int CMD_LO = 10;
  localparam logic [FN_W-1:0] FN2_OPERAND = 4'h2;
  localparam logic [FN_W-1:0] FN2_TRAP = 4'h3;
  localparam logic [FN_W-1:0] FN2_UPC = 4'h4;
  localparam logic [FN_W-1:0] FN1_SEL_SET = 4'h8;
  localparam logic [FN_W-1:0] FN1_SEL_CLR = 4'h9;
  localparam logic [DP_W-1:0] DP_READ = 3'h5;
  localparam logic [1:0] WORD_WAIT = 2'h1;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_AUX,
    OP_XFER
  } op_kind_t;

  // one decoded microword as presented by the sequencer
  typedef struct packed {
    op_kind_t kind;
    logic [19:0] ctl;
    logic [FN_W-1:0] fn1;
    logic [FN_W-1:0] fn2;
    logic [DP_W-1:0] dp;
    logic [ADDR_W-1:0] d_addr;
    logic [DATA_W-1:0] wreg;
    logic long_read;
  } uword_t;

  // signals driven toward the accelerator / port device
  typedef struct packed {
    logic [DATA_W-1:0] bus_out;
    logic bus_oe_n;
    logic operand_offer;
    logic fetch_request;
    logic accel_select;
    logic accel_trap;
    logic upc_read_request;
    logic command_strobe;
    logic [CMD_W-1:0] command_byte;
  } link_out_t;

  // result written into local store
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } store_wr_t;
endpackage

// File: design/two_flop_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module two_flop_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // level in and out
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_st_t;
  sync_st_t st;
  sync_st_t next_st;

  always_comb begin
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.s2;
endmodule
`default_nettype wire

// File: design/cop_data_port.sv
// cpu side of the shared data bus to the accelerator and port devices
//
// Functional notes
// - aux microword drives working register; fn2 of 2 also asserts operand_offer.
// - operands go one 32-bit word per aux microword until all sent.
// - accelerator raises ready when it can accept; operand microword repeats while low.
// - transfer with data path 5 floats bus, asserts fetch, stores word at D.
// - result moves only with fetch and ready together; read repeats while ready low.
// - accel_select set by fn1 of 8, cleared by 9; set before result reads.
// - fn2 of 3 asserts accel_trap and drives the microaddress on the bus.
// - fn2 of 4 then data path 5 reads the counter with no looping.
// - control bit 18 makes a port command; bits 17 to 10 form the byte.
// - port command asserts command_strobe and drives a working register too.
// - port reads assert fetch, expect no handshake, take the first-cycle word.
// - long word port read waits two cycles after its command.
// - after an automatic buffer read command, reads repeat with no new command.
// - accel_select must be clear before port commands or port reads; only a port command with it set raises seq_error.
`timescale 1ns/100ps
`default_nettype none
module cop_data_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // microword from the sequencer
  input wire logic uword_valid,
  input wire cop_port_pkg::uword_t uword,
  output logic uword_done,
  output logic uword_repeat,
  output logic seq_error,
  // link pins
  input wire logic [cop_port_pkg::DATA_W-1:0] bus_in,
  input wire logic accel_ready_handshake,
  output cop_port_pkg::link_out_t link,
  // local store write
  output cop_port_pkg::store_wr_t store
);
  import cop_port_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT
  } phase_t;

  typedef struct packed {
    phase_t phase;
    link_out_t link;
    store_wr_t store;
    logic done;
    logic rep;
    logic err;
    logic upc_pending;
    logic [1:0] since_cmd;
  } state_t;

  state_t st;
  state_t next_st;
  logic local_rstn;
  logic is_aux;
  logic is_port;
  logic is_read;
  logic hold_long;

  // reset release synchroniser
  two_flop_sync rst_sync_i (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .din(1'b1),
    .dout(local_rstn)
  );

  assign is_aux = uword_valid && uword.kind == OP_AUX;
  assign is_port = is_aux && uword.ctl[PORT_BIT];
  assign is_read = uword_valid && uword.kind == OP_XFER && uword.dp == DP_READ;
  assign hold_long = is_read && !st.link.accel_select && uword.long_read
    && st.since_cmd < WORD_WAIT + 2'h1;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.rep = 1'b0;
    next_st.err = 1'b0;
    next_st.store.we = 1'b0;
    next_st.link.operand_offer = 1'b0;
    next_st.link.fetch_request = 1'b0;
    next_st.link.accel_trap = 1'b0;
    next_st.link.upc_read_request = 1'b0;
    next_st.link.command_strobe = 1'b0;
    next_st.link.bus_oe_n = 1'b1;
    if (st.since_cmd != 2'h3) begin
      next_st.since_cmd = st.since_cmd + 2'h1;
    end
    unique case (st.phase)
      ST_IDLE: begin
        if (is_port) begin
          next_st.link.command_byte = uword.ctl[CMD_HI:CMD_LO];
          next_st.link.command_strobe = 1'b1;
          next_st.link.bus_out = uword.wreg;
          next_st.link.bus_oe_n = 1'b0;
          next_st.since_cmd = 2'h0;
          next_st.err = st.link.accel_select;
          next_st.done = 1'b1;
        end else if (is_aux) begin
          next_st.link.bus_out = uword.wreg;
          next_st.link.bus_oe_n = 1'b0;
          if (uword.fn1 == FN1_SEL_SET) begin
            next_st.link.accel_select = 1'b1;
          end else if (uword.fn1 == FN1_SEL_CLR) begin
            next_st.link.accel_select = 1'b0;
          end
          next_st.upc_pending = uword.fn2 == FN2_UPC;
          next_st.link.upc_read_request = uword.fn2 == FN2_UPC;
          next_st.link.accel_trap = uword.fn2 == FN2_TRAP;
          if (uword.fn2 == FN2_OPERAND) begin
            next_st.link.operand_offer = 1'b1;
            next_st.phase = ST_WAIT;
          end else begin
            next_st.done = 1'b1;
          end
        end else if (is_read && !hold_long) begin
          next_st.link.fetch_request = 1'b1;
          next_st.link.bus_oe_n = 1'b1;
          next_st.store.addr = uword.d_addr;
          next_st.phase = ST_WAIT;
        end else if (uword_valid) begin
          next_st.upc_pending = 1'b0;
          next_st.done = !hold_long;
          next_st.rep = hold_long;
        end
      end
      ST_WAIT: begin
        if (st.link.operand_offer) begin
          next_st.link.bus_oe_n = 1'b0;
          if (accel_ready_handshake) begin
            next_st.link.operand_offer = 1'b0;
            next_st.link.bus_oe_n = 1'b1;
            next_st.done = 1'b1;
            next_st.phase = ST_IDLE;
          end else begin
            next_st.link.operand_offer = 1'b1;
            next_st.rep = 1'b1;
          end
        end else if (!st.link.accel_select || st.upc_pending || accel_ready_handshake) begin
          // port and counter reads take first word
          // automatic buffer reads need no command
          next_st.store.we = 1'b1;
          next_st.store.data = bus_in;
          next_st.upc_pending = 1'b0;
          next_st.done = 1'b1;
          next_st.phase = ST_IDLE;
        end else begin
          next_st.link.fetch_request = 1'b1;
          next_st.rep = 1'b1;
        end
      end
      default: begin
        next_st.phase = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge local_rstn) begin
    if (!local_rstn) begin
      st <= '0;
      st.link.bus_oe_n <= 1'b1;
      st.since_cmd <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  assign link = st.link;
  assign store = st.store;
  assign uword_done = st.done;
  assign uword_repeat = st.rep;
  assign seq_error = st.err;

  // select set and clear
  sel_set_a: assert property (@(posedge ref_clk) disable iff (!local_rstn)
    local_rstn && st.phase == ST_IDLE && is_aux && !is_port && uword.fn1 == FN1_SEL_SET
      |=> link.accel_select) else $error("select not set");
  sel_clr_a: assert property (@(posedge ref_clk) disable iff (!local_rstn)
    local_rstn && st.phase == ST_IDLE && is_aux && !is_port && uword.fn1 == FN1_SEL_CLR
      |=> !link.accel_select) else $error("select not cleared");
  offer_drive_a: assert property (@(posedge ref_clk) disable iff (!local_rstn)
    link.operand_offer |-> !link.bus_oe_n) else $error("offer without drive");
  offer_hold_a: assert property (@(posedge ref_clk) disable iff (!local_rstn)
    link.operand_offer && !accel_ready_handshake |=> link.operand_offer)
    else $error("offer dropped");
  fetch_float_a: assert property (@(posedge ref_clk) disable iff (!local_rstn)
    link.fetch_request |-> link.bus_oe_n) else $error("bus driven during fetch");
  store_cause_a: assert property (@(posedge ref_clk) disable iff (!local_rstn)
    store.we |-> $past(link.fetch_request)) else $error("store without fetch");
  trap_drive_a: assert property (@(posedge ref_clk) disable iff (!local_rstn)
    link.accel_trap |-> !link.bus_oe_n) else $error("trap without address");
  cmd_byte_a: assert property (@(posedge ref_clk) disable iff (!local_rstn)
    local_rstn && st.phase == ST_IDLE && is_port
      |=> link.command_strobe && link.command_byte == $past(uword.ctl[CMD_HI:CMD_LO]))
    else $error("command byte wrong");
  port_sel_a: assert property (@(posedge ref_clk) disable iff (!local_rstn)
    link.command_strobe && link.accel_select |-> seq_error) else $error("missing error");
  upc_noloop_a: assert property (@(posedge ref_clk) disable iff (!local_rstn)
    link.upc_read_request ##1 link.fetch_request |=> store.we)
    else $error("counter read looped");

  offer_cov: cover property (@(posedge ref_clk) link.operand_offer ##1 uword_done);
  read_cov: cover property (@(posedge ref_clk) link.fetch_request ##1 store.we);
  port_cov: cover property (@(posedge ref_clk) link.command_strobe ##[1:4] store.we);
endmodule
`default_nettype wire

// File: sim/far_end_model.sv
// far side model: accelerator and one port device on the shared data bus
`timescale 1ns/100ps
`default_nettype none
module far_end_model
  import cop_port_pkg::*;
#(
  parameter logic [31:0] RESULT = 32'h5a5a0f0f,
  parameter logic [1:0] DEV_ADDR = 2'h3,
  parameter logic [7:0] AUTO = 8'hc1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // from the cpu side
  input wire cop_port_pkg::link_out_t link,
  input wire logic [3:0] slow,
  // toward the cpu side
  output logic [31:0] bus_in,
  output logic accel_ready_handshake,
  output logic [31:0] got,
  output logic [7:0] n_got
);
  logic [3:0] cnt;
  logic [31:0] upc, preg, last;
  logic [7:0] cmd, idx;
  logic upc_pend, fetch_q, drv;
  always_comb begin
    drv = link.fetch_request && (link.accel_select ? (accel_ready_handshake || upc_pend)
      : (cmd[7:6] == DEV_ADDR));
    if (!link.accel_select) bus_in = preg + {24'h0, idx};
    else bus_in = upc_pend ? upc : RESULT;
    if (!drv) bus_in = ~last;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 4'h0;
      upc <= 32'h0;
      preg <= 32'h0;
      last <= 32'h0;
      cmd <= 8'h0;
      idx <= 8'h0;
      upc_pend <= 1'b0;
      fetch_q <= 1'b0;
      got <= 32'h0;
      n_got <= 8'h0;
      accel_ready_handshake <= 1'b0;
    end else begin
      last <= bus_in;
      fetch_q <= link.fetch_request;
      if (!accel_ready_handshake) cnt <= cnt + 4'h1;
      if (!accel_ready_handshake && cnt >= slow) accel_ready_handshake <= 1'b1;
      if (link.operand_offer && accel_ready_handshake) begin
        got <= link.bus_out;
        n_got <= n_got + 8'h1;
        accel_ready_handshake <= 1'b0;
        cnt <= '0;
      end
      if (link.accel_trap) upc <= link.bus_out;
      if (link.upc_read_request) upc_pend <= 1'b1;
      if (link.fetch_request && upc_pend) accel_ready_handshake <= 1'b1;
      if (link.command_strobe) begin
        cmd <= link.command_byte;
        preg <= link.bus_out;
        idx <= '0;
      end
      if (fetch_q && !link.fetch_request) begin
        upc_pend <= 1'b0;
        if (link.accel_select && !upc_pend) accel_ready_handshake <= 1'b0;
        if (cmd == AUTO) idx <= idx + 8'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/cop_data_port_test.sv
// self-checking bench for the coprocessor data bus port
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module cop_data_port_test;
  import cop_port_pkg::*;
  typedef struct packed {logic fetch, offer, strobe, trap, upc, we, rep, err;} seen_t;
  logic ref_clk, rstn, uv, ready, done, rep, err;
  logic [3:0] slow, s_addr;
  logic [31:0] bus_in, got, s_data;
  logic [7:0] n_got;
  seen_t s;
  uword_t uw;
  link_out_t link;
  store_wr_t store;
  int n_errors, checks_done;
  cop_data_port u_dut (.ref_clk(ref_clk), .rstn(rstn), .uword_valid(uv), .uword(uw),
    .uword_done(done), .uword_repeat(rep), .seq_error(err), .bus_in(bus_in),
    .accel_ready_handshake(ready), .link(link), .store(store));
  far_end_model u_far (.ref_clk(ref_clk), .rstn(rstn), .link(link), .slow(slow),
    .bus_in(bus_in), .accel_ready_handshake(ready), .got(got), .n_got(n_got));
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic run(input op_kind_t k, input logic [19:0] c, input logic [3:0] f1, f2,
    input logic [31:0] w, input logic [3:0] a, input logic lr);
    int n = 0;
    uw = '{kind: k, ctl: c, fn1: f1, fn2: f2, dp: DP_READ, d_addr: a, wreg: w, long_read: lr};
    uv = 1'b1;
    s = '0;
    do begin
      @(posedge ref_clk);
      #2;
      n++;
      s |= {link.fetch_request, link.operand_offer, link.command_strobe, link.accel_trap,
        link.upc_read_request, store.we, rep, err};
      if (store.we) s_data = store.data;
      if (store.we) s_addr = store.addr;
    end while (done !== 1'b1 && n < 200);
    `CHK("uword_done", 1'b1, done)
  endtask
  task automatic aux(input logic [3:0] f1, f2, input logic [31:0] w);
    run(OP_AUX, 20'h0, f1, f2, w, 4'h0, 1'b0);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [31:0] w);
    run(OP_AUX, {2'b01, c, 10'h0}, 4'h0, 4'h0, w, 4'h0, 1'b0);
  endtask
  task automatic rd(input logic [3:0] a, input logic lr);
    run(OP_XFER, 20'h0, 4'h0, 4'h0, 32'h0, a, lr);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #(25 * 4000);
    n_errors++;
    close_out();
  end
  initial begin
    rstn = 1'b0;
    uv = 1'b0;
    uw = '0;
    slow = 4'h0;
    repeat (6) @(posedge ref_clk);
    #2;
    rstn = 1'b1;
    `CHK("bus_oe_n", 1'b1, link.bus_oe_n)
    aux(FN1_SEL_SET, 4'h0, 32'h0);
    `CHK("accel_select", 1'b1, link.accel_select)
    for (int i = 0; i < 3; i++) begin
      aux(4'h0, FN2_OPERAND, 32'h1000 + i);
      `CHK("offer", 1'b1, s.offer)
    end
    `CHK("n_got", 8'h3, n_got)
    `CHK("got", 32'h1002, got)
    slow = 4'h6;
    aux(4'h0, FN2_OPERAND, 32'hbeef);
    `CHK("looped", 2'h3, {s.rep, got === 32'hbeef})
    aux(4'h0, 4'h0, 32'h77);
    `CHK("offer", 1'b0, s.offer)
    rd(4'h3, 1'b0);
    `CHK("store", {4'h3, 32'h5a5a0f0f}, {s_addr, s_data})
    `CHK("fetch", 2'h3, {s.fetch, s.rep})
    aux(4'h0, FN2_TRAP, 32'h1f0);
    `CHK("trap", 1'b1, s.trap)
    aux(4'h0, FN2_UPC, 32'h0);
    `CHK("upc request", 1'b1, s.upc)
    rd(4'h4, 1'b0);
    `CHK("upc", 32'h1f0, s_data)
    aux(FN1_SEL_CLR, 4'h0, 32'h0);
    `CHK("accel_select", 1'b0, link.accel_select)
    cmd(8'hc0, 32'h100);
    `CHK("cmd byte", {1'b1, 8'hc0}, {s.strobe, link.command_byte})
    rd(4'h5, 1'b0);
    `CHK("port data", 32'h100, s_data)
    cmd(8'hc1, 32'h200);
    for (int i = 0; i < 3; i++) begin
      rd(4'h6, 1'b1);
      `CHK("auto data", 32'h200 + i, s_data)
      if (i == 0) `CHK("spacing", 1'b1, s.rep)
    end
    aux(FN1_SEL_SET, 4'h0, 32'h0);
    cmd(8'hc0, 32'h0);
    `CHK("seq_error", 1'b1, s.err)
    uv = 1'b0;
    close_out();
  end
endmodule
`default_nettype wire
